// [core/wdtc_top.sv]
// Timeout supervisor control: control register, timed unlock and fuse levels.
// Assumes a plain register port on core_clk and a free-running oscillator pin.
`timescale 1ns/1ps
module wdtc_top
    import wdtc_pkg::*;
#(
    parameter int BASE_LOG2 = WDTC_BASE_LOG2
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Kick from the processor core
    input wire logic kick,
    // Fuse and oscillator pins
    input wire logic safety_level_fuse,
    input wire logic wd_osc,
    // Reset request to the chip reset logic
    output logic chip_reset_req
);

    localparam int CNT_W = BASE_LOG2 + 7;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic fuse_s1_r;
    logic fuse_s2_r;
    logic fuse_done_r;
    logic fuse_lvl2_r;
    logic watchdog_on_bit_r;
    logic watchdog_on_bit_nxt;
    logic [WDTC_PER_W-1:0] period_select_field_r;
    logic [WDTC_PER_W-1:0] period_select_field_nxt;
    logic [2:0] unlock_cnt_r;
    logic [2:0] unlock_cnt_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic ctrl_sel;
    logic stat_sel;
    logic wr_ctrl;
    logic wr_on;
    logic wr_unlock;
    logic [WDTC_PER_W-1:0] wr_per;
    logic window_open;
    logic unlock_req;
    logic timed_write;
    logic on_eff;
    logic change_unlock_bit;
    logic [7:0] ctrl_view;
    logic [7:0] stat_view;
    logic timeout;
    logic [CNT_W-1:0] count;

    // ****************************************************************
    // Fuse capture
    // ****************************************************************
    // Fuse synchroniser runs through reset, so stage two already holds
    // the pin level when the capture flop looks at it after release
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            fuse_s1_r <= safety_level_fuse;
            fuse_s2_r <= fuse_s1_r;
        end
    end

    // Level frozen on the first enabled cycle after reset so no later
    // pin change or write can move it
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fuse_done_r <= 1'b0;
            fuse_lvl2_r <= 1'b0;
        end else if (clk_en) begin
            fuse_done_r <= 1'b1;
            if (!fuse_done_r) begin
                fuse_lvl2_r <= fuse_s2_r;
            end
        end
    end

    // ****************************************************************
    // Write decode
    // ****************************************************************
    // Unmapped addresses decode to nothing and are dropped
    assign ctrl_sel = (reg_addr == WDTC_CTRL_ADDR);
    assign stat_sel = (reg_addr == WDTC_STAT_ADDR);
    assign wr_ctrl = reg_wr && ctrl_sel;
    assign wr_on = reg_wdata[WDTC_ON_BIT];
    assign wr_unlock = reg_wdata[WDTC_UNLOCK_BIT];
    assign wr_per = reg_wdata[WDTC_PER_LSB +: WDTC_PER_W];
    assign window_open = (unlock_cnt_r != 3'h0);
    assign change_unlock_bit = window_open;
    // Unlock needs both bits in one write, even if enable already reads one
    assign unlock_req = wr_ctrl && wr_unlock && wr_on;
    assign timed_write = wr_ctrl && !wr_unlock && window_open;
    assign on_eff = watchdog_on_bit_r || fuse_lvl2_r;

    // ****************************************************************
    // Next-state for enable, period and unlock window
    // ****************************************************************
    // Level one: setting enable is free, clearing needs the window.
    // Level two: enable is forced, so the written value is dropped.
    assign watchdog_on_bit_nxt = fuse_lvl2_r ? watchdog_on_bit_r :
                                 (wr_ctrl && wr_on) ? 1'b1 :
                                 timed_write ? wr_on :
                                 watchdog_on_bit_r;
    // Period moves only on the one write inside the window
    assign period_select_field_nxt = timed_write ? wr_per : period_select_field_r;
    // The window closes after four cycles or after its one write
    assign unlock_cnt_nxt = unlock_req ? WDTC_UNLOCK_CYCLES :
                            timed_write ? 3'h0 :
                            window_open ? unlock_cnt_r - 3'h1 : 3'h0;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            watchdog_on_bit_r <= WDTC_ON_RST;
            period_select_field_r <= WDTC_PER_RST;
            unlock_cnt_r <= 3'h0;
        end else if (clk_en) begin
            watchdog_on_bit_r <= watchdog_on_bit_nxt;
            period_select_field_r <= period_select_field_nxt;
            unlock_cnt_r <= unlock_cnt_nxt;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Reserved control bits read as zero; data stands one cycle only
    assign ctrl_view = {3'h0, change_unlock_bit, on_eff, period_select_field_r};
    assign stat_view = {5'h00, on_eff, fuse_lvl2_r, window_open};
    assign rdata_nxt = !reg_rd ? 8'h00 :
                       ctrl_sel ? ctrl_view :
                       stat_sel ? stat_view : 8'h00;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (clk_en) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // ****************************************************************
    // Timeout counter
    // ****************************************************************
    // Same clock domain, so kick and period reach the counter directly;
    // only the oscillator pin needs a synchroniser inside the counter
    wdtc_counter #(
        .BASE_LOG2(BASE_LOG2),
        .CNT_W(CNT_W)
    ) u_counter (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .wd_osc(wd_osc),
        .run(on_eff),
        .clear(kick),
        .period_sel(period_select_field_r),
        .timeout(timeout),
        .count(count)
    );

    // One-cycle pulse; the chip reset logic brings rst_n back to us
    assign chip_reset_req = timeout;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking chk_cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n || !clk_en);

    sequence s_unlock;
        unlock_req;
    endsequence

    sequence s_quiet4;
        (!reg_wr) [*4];
    endsequence

    sequence s_quiet3;
        (!reg_wr) [*3];
    endsequence

    chk_window_closes: assert property (s_unlock ##1 s_quiet4 |=> !window_open)
        else $error("unlock window open after four cycles");
    chk_window_held: assert property (s_unlock ##1 s_quiet3 |-> window_open)
        else $error("unlock window closed early");
    chk_clear_guarded: assert property ($fell(watchdog_on_bit_r) |-> $past(window_open) && !fuse_lvl2_r)
        else $error("enable cleared without unlock");
    chk_lvl2_never_off: assert property (fuse_done_r && fuse_lvl2_r |-> on_eff)
        else $error("level two supervisor stopped");
    chk_lvl2_reads_on: assert property (reg_rd && ctrl_sel && fuse_lvl2_r |=> reg_rdata[WDTC_ON_BIT])
        else $error("level two enable read as zero");
    chk_enable_free: assert property (wr_ctrl && wr_on && !fuse_lvl2_r |=> watchdog_on_bit_r)
        else $error("enable write not honoured");
    chk_timed_period: assert property (timed_write |=> period_select_field_r == $past(wr_per))
        else $error("timed write did not set period");
    chk_period_guard: assert property (!timed_write |=> $stable(period_select_field_r))
        else $error("period changed outside unlock window");
    chk_fuse_frozen: assert property (fuse_done_r |=> $stable(fuse_lvl2_r))
        else $error("safety level changed after capture");
    chk_reset_pulse: assert property (chip_reset_req |=> !chip_reset_req)
        else $error("reset request longer than one cycle");
    chk_off_disable_clear: assert property (timed_write && !wr_on && !fuse_lvl2_r ##1 1 |=> count == '0)
        else $error("counter not cleared after disable");

endmodule

// [include/wdtc_pkg.sv]
// Constants shared by the timeout supervisor control block and its counter.
// Assumes an 8-bit register port and a single 100 MHz core clock.
package wdtc_pkg;

    // ****************************************************************
    // Register map and field layout
    // ****************************************************************
    localparam logic [7:0] WDTC_CTRL_ADDR = 8'h00;
    localparam logic [7:0] WDTC_STAT_ADDR = 8'h01;
    localparam int WDTC_PER_LSB = 0;
    localparam int WDTC_PER_W = 3;
    localparam int WDTC_ON_BIT = 3;
    localparam int WDTC_UNLOCK_BIT = 4;
    localparam int WDTC_STAT_WIN_BIT = 0;
    localparam int WDTC_STAT_LVL2_BIT = 1;
    localparam int WDTC_STAT_RUN_BIT = 2;

    // ****************************************************************
    // Reset values and timing
    // ****************************************************************
    localparam logic [2:0] WDTC_PER_RST = 3'h0;
    localparam logic WDTC_ON_RST = 1'b0;
    localparam logic [2:0] WDTC_UNLOCK_CYCLES = 3'h4;
    localparam int WDTC_BASE_LOG2 = 14;
    localparam int WDTC_CNT_W = WDTC_BASE_LOG2 + 7;

endpackage

// [core/wdtc_counter.sv]
// Timeout counter stepped by the watchdog oscillator pin.
// Assumes the oscillator is far slower than core_clk, so each of its
// rising edges is seen as one tick after a two-flop synchroniser.
`timescale 1ns/1ps
module wdtc_counter
    import wdtc_pkg::*;
#(
    parameter int BASE_LOG2 = WDTC_BASE_LOG2,
    parameter int CNT_W = WDTC_CNT_W
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Oscillator pin, asynchronous to core_clk
    input wire logic wd_osc,
    // Control from the register side, plus the kick as clear
    input wire logic run,
    input wire logic clear,
    input wire logic [WDTC_PER_W-1:0] period_sel,
    // Results
    output logic timeout,
    output logic [CNT_W-1:0] count
);

    // ****************************************************************
    // Oscillator synchroniser and edge detect
    // ****************************************************************
    logic osc_s1_r;
    logic osc_s2_r;
    logic osc_s3_r;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic timeout_r;
    logic timeout_nxt;
    logic [CNT_W:0] limit_full;
    logic [CNT_W-1:0] limit_m1;
    logic tick;
    logic at_limit;

    // First stage feeds only the second; edge detect looks at stage two
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_s3_r <= 1'b0;
        end else if (clk_en) begin
            osc_s1_r <= wd_osc;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
        end
    end

    // ****************************************************************
    // Period decode and count
    // ****************************************************************
    // Each code doubles the oscillator cycle count from the base
    assign limit_full = (CNT_W+1)'(1) << (BASE_LOG2 + int'(period_sel));
    assign limit_m1 = CNT_W'(limit_full - (CNT_W+1)'(1));
    assign tick = osc_s2_r & ~osc_s3_r;
    assign at_limit = (count_r >= limit_m1);
    // A shortened period below the running count expires on the next tick
    assign count_nxt = (clear || !run) ? '0 :
                       (tick && at_limit) ? '0 :
                       tick ? count_r + CNT_W'(1) : count_r;
    assign timeout_nxt = run && !clear && tick && at_limit;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            count_r <= '0;
            timeout_r <= 1'b0;
        end else if (clk_en) begin
            count_r <= count_nxt;
            timeout_r <= timeout_nxt;
        end
    end

    assign timeout = timeout_r;
    assign count = count_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_count_cleared: assert property (@(posedge core_clk) disable iff (!rst_n || !clk_en)
        (clear || !run) |=> (count_r == '0))
        else $error("counter not cleared by kick or disable");
    chk_timeout_limit: assert property (@(posedge core_clk) disable iff (!rst_n || !clk_en)
        timeout_r |-> ($past(count_r) >= $past(limit_m1)) && (count_r == '0))
        else $error("timeout without reaching the selected count");

endmodule

// [test/wdtc_tb.sv]
// Self-checking bench for the timeout supervisor control block.
// Assumes wdtc_pkg is compiled first; the bench drives every port of wdtc_top.
`timescale 1ns/1ps
module tb
    import wdtc_pkg::*;
;
    // ****************************************************************
    // Signals and bookkeeping
    // ****************************************************************
    localparam int TB_LOG2 = 2;
    localparam int LIMIT = 6000;
    localparam logic [7:0] ctl_a = WDTC_CTRL_ADDR;
    localparam logic [7:0] st_a = WDTC_STAT_ADDR;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic kick = 1'b0;
    logic safety_level_fuse = 1'b0;
    logic wd_osc = 1'b0;
    logic chip_reset_req;
    logic [7:0] exp_q[$];
    logic [7:0] rst_seen = 8'h00;
    logic [7:0] rnd;
    logic rd_d = 1'b0;
    int fails = 0;
    int compares = 0;
    int cyc = 0;
    int seed = 79922;

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    wdtc_top #(.BASE_LOG2(TB_LOG2)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .kick(kick),
        .safety_level_fuse(safety_level_fuse), .wd_osc(wd_osc),
        .chip_reset_req(chip_reset_req)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] ctl(logic un, logic on, logic [2:0] p);
        return (8'(un) << WDTC_UNLOCK_BIT) | (8'(on) << WDTC_ON_BIT) | (8'(p) << WDTC_PER_LSB);
    endfunction

    function automatic logic [7:0] st(logic win, logic l2, logic run);
        return (8'(win) << WDTC_STAT_WIN_BIT) | (8'(l2) << WDTC_STAT_LVL2_BIT) | (8'(run) << WDTC_STAT_RUN_BIT);
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want) begin
            fails++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask

    task automatic wrap_up;
        $display("Counts: %0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Strobes stay up across back-to-back calls; idle drops them
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        @(posedge core_clk);
        exp_q.push_back(want);
        reg_addr <= a;
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge core_clk);
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            kick <= 1'b0;
        end
    endtask

    task automatic do_kick;
        idle(1);
        kick <= 1'b1;
        idle(1);
    endtask

    // Oscillator high and low four core cycles each, well above the minimum
    task automatic tick(input int n);
        idle(1);
        repeat (n) begin
            wd_osc <= 1'b1;
            repeat (4) @(posedge core_clk);
            wd_osc <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
    endtask

    task automatic do_reset(input logic fuse);
        idle(1);
        safety_level_fuse <= fuse;
        rst_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask

    // Monitor: read data one cycle after the strobe, reset pulses, hang limit
    always @(posedge core_clk) begin
        cyc++;
        if (chip_reset_req === 1'b1) rst_seen <= rst_seen + 8'h01;
        rd_d <= (reg_rd === 1'b1) && (rst_n === 1'b1);
        if (rd_d && exp_q.size() > 0) check(reg_rdata, exp_q.pop_front());
        if (cyc == LIMIT) begin
            fails++;
            wrap_up();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        do_reset(1'b0);
        rd(ctl_a, ctl(0, 0, 3'h0));
        rd(st_a, st(0, 0, 0));
        rd(8'h80, 8'h00);
        wr(ctl_a, 8'he0);
        rd(ctl_a, 8'h00);
        tick(6);
        check(rst_seen, 8'h00);
        wr(ctl_a, ctl(0, 1, 3'h5));
        rd(ctl_a, ctl(0, 1, 3'h0));
        rd(st_a, st(0, 0, 1));
        wr(ctl_a, ctl(0, 0, 3'h0));
        rd(ctl_a, ctl(0, 1, 3'h0));
        // Late timed write lands one cycle past the window
        wr(ctl_a, ctl(1, 1, 3'h0));
        rd(ctl_a, ctl(1, 1, 3'h0));
        rd(st_a, st(1, 0, 1));
        idle(2);
        wr(ctl_a, ctl(0, 0, 3'h7));
        rd(ctl_a, ctl(0, 1, 3'h0));
        // Every period code, timed write at t+1 through t+4
        for (int c = 0; c < 8; c++) begin
            wr(ctl_a, ctl(1, 1, 3'h0));
            idle(c % 4);
            wr(ctl_a, ctl(0, 1, 3'(c)));
            rd(ctl_a, ctl(0, 1, 3'(c)));
        end
        wr(ctl_a, ctl(1, 1, 3'h7));
        wr(ctl_a, ctl(0, 1, 3'h0));
        do_kick;
        tick(3);
        check(rst_seen, 8'h00);
        tick(1);
        check(rst_seen, 8'h01);
        tick(3);
        do_kick;
        tick(3);
        check(rst_seen, 8'h01);
        tick(1);
        check(rst_seen, 8'h02);
        wr(ctl_a, ctl(1, 1, 3'h0));
        wr(ctl_a, ctl(0, 1, 3'h1));
        do_kick;
        tick(7);
        check(rst_seen, 8'h02);
        tick(1);
        check(rst_seen, 8'h03);
        // Random traffic to unmapped and read-only places
        for (int i = 0; i < 8; i++) begin
            rnd = 8'($random(seed));
            wr(8'h02 | (rnd & 8'h7c), rnd);
            wr(st_a, rnd);
        end
        rd(ctl_a, ctl(0, 1, 3'h1));
        wr(ctl_a, ctl(1, 1, 3'h1));
        wr(ctl_a, ctl(0, 0, 3'h1));
        rd(ctl_a, ctl(0, 0, 3'h1));
        wr(ctl_a, ctl(1, 0, 3'h0));
        wr(ctl_a, ctl(0, 0, 3'h4));
        rd(ctl_a, ctl(0, 0, 3'h1));
        tick(10);
        check(rst_seen, 8'h03);
        // Level two after a second reset
        do_reset(1'b1);
        rd(ctl_a, ctl(0, 1, 3'h0));
        rd(st_a, st(0, 1, 1));
        wr(ctl_a, ctl(1, 1, 3'h0));
        wr(ctl_a, ctl(0, 0, 3'h0));
        rd(ctl_a, ctl(0, 1, 3'h0));
        wr(ctl_a, ctl(1, 1, 3'h0));
        idle(3);
        wr(ctl_a, ctl(0, 0, 3'h2));
        rd(ctl_a, ctl(0, 1, 3'h2));
        wr(ctl_a, ctl(1, 0, 3'h0));
        wr(ctl_a, ctl(0, 0, 3'h5));
        rd(ctl_a, ctl(0, 1, 3'h2));
        do_kick;
        tick(15);
        check(rst_seen, 8'h03);
        tick(1);
        check(rst_seen, 8'h04);
        // Low clock enable freezes the unlock window countdown
        wr(ctl_a, ctl(1, 1, 3'h0));
        @(posedge core_clk);
        reg_wr <= 1'b0;
        clk_en <= 1'b0;
        repeat (6) @(posedge core_clk);
        clk_en <= 1'b1;
        wr(ctl_a, ctl(0, 0, 3'h3));
        rd(ctl_a, ctl(0, 1, 3'h3));
        idle(3);
        check(8'(exp_q.size()), 8'h00);
        wrap_up();
    end
endmodule
